// ### logic/smbus_defs.svh
// constants for both ends of the two-wire memory port, each used by one end
`ifndef SMBUS_DEFS_SVH
`define SMBUS_DEFS_SVH

`define CLK_FREQ_HZ 20000000
`define TICK_RATE_HZ 2
`define TICK_CYCLES (`CLK_FREQ_HZ / `TICK_RATE_HZ)
`define EE_WRITE_TIME_US 4000
`define EE_WRITE_CYCLES (`EE_WRITE_TIME_US * (`CLK_FREQ_HZ / 1000000))

`define SLAVE_ADDR 7'h0B
`define BANK_EEPROM 2'h0
`define BANK_REGS 2'h1
`define EE_SIZE 10'h200
`define RAM_SIZE 10'h020
`define OFS_COUNTERS 7'h04
`define OFS_ACC_CLR 10'h062
`define OFS_ACC_CTRL 10'h063

`define HDR_BLOCK_BIT 7
`define HDR_BANK_HI 5
`define HDR_BANK_LO 4
`define HDR_AH_HI 1
`define CLR_SUM_BIT 0
`define CLR_TIME_BIT 1
`define ACC_EN_BIT 0
`define SIGN_BIT 15
`define ACC_CTRL_RESET 8'h00

`define HOST_QUARTER 8'h19
`define WB_CMD 8'h00
`define WB_STATUS 8'h04
`define CMD_START_BIT 8
`define CMD_STOP_BIT 9
`define CMD_READ_BIT 10
`define CMD_NACK_BIT 11

`endif

// ### logic/smbus_host_master.sv
// bus master end, driven by byte commands over wishbone
`timescale 1ns/1ps
`default_nettype none
`include "smbus_defs.svh"
module smbus_host_master (
    input wire logic clk,
    input wire logic reset,
    smbus_link_if.host link,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o
);
    smbus_pkg::host_state_type state_reg;
    logic [1:0] sda_sync_reg;
    logic [7:0] q_cnt_reg;
    logic [1:0] phase_reg;
    logic [3:0] bit_idx_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic do_stop_reg;
    logic do_read_reg;
    logic nack_last_reg;
    logic got_nack_reg;
    logic scl_low_reg;
    logic sda_low_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic access;
    logic cmd_take;
    logic step;
    logic busy;

    assign access = wb_cyc_i && wb_stb_i && !ack_reg;
    assign busy = state_reg != smbus_pkg::HS_IDLE;
    assign cmd_take = access && wb_we_i && wb_adr_i == `WB_CMD
        && wb_sel_i[1:0] == 2'h3 && !busy;
    assign step = q_cnt_reg == `HOST_QUARTER - 8'h01;

    always_ff @(posedge clk) begin
        if (reset) begin
            sda_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
        end
    end

    // quarter-period divider for the bus clock
    always_ff @(posedge clk) begin
        if (reset || cmd_take || step) begin
            q_cnt_reg <= 8'h00;
        end else begin
            q_cnt_reg <= q_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= access;
            if (access && !wb_we_i) begin
                dat_reg <= (wb_adr_i == `WB_STATUS)
                    ? {16'h0000, rx_reg, 6'h00, got_nack_reg, busy}
                    : 32'h00000000;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= smbus_pkg::HS_IDLE;
            phase_reg <= 2'h0;
            bit_idx_reg <= 4'h0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            do_stop_reg <= 1'b0;
            do_read_reg <= 1'b0;
            nack_last_reg <= 1'b0;
            got_nack_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end else if (cmd_take) begin
            tx_reg <= wb_dat_i[7:0];
            do_stop_reg <= wb_dat_i[`CMD_STOP_BIT];
            do_read_reg <= wb_dat_i[`CMD_READ_BIT];
            nack_last_reg <= wb_dat_i[`CMD_NACK_BIT];
            got_nack_reg <= 1'b0;
            phase_reg <= 2'h0;
            bit_idx_reg <= 4'h0;
            state_reg <= wb_dat_i[`CMD_START_BIT]
                ? smbus_pkg::HS_START : smbus_pkg::HS_BIT;
        end else if (step && busy) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (state_reg)
                smbus_pkg::HS_START: begin
                    // also a repeated start when the clock is held low
                    unique case (phase_reg)
                        2'h0: sda_low_reg <= 1'b0;
                        2'h1: scl_low_reg <= 1'b0;
                        2'h2: sda_low_reg <= 1'b1; // [R2]
                        2'h3: begin
                            scl_low_reg <= 1'b1;
                            state_reg <= smbus_pkg::HS_BIT;
                        end
                    endcase
                end
                smbus_pkg::HS_BIT: begin
                    unique case (phase_reg)
                        2'h0: begin
                            if (bit_idx_reg == 4'h8) begin
                                sda_low_reg <= do_read_reg
                                    && !nack_last_reg; // [R5]
                            end else begin
                                sda_low_reg <= !do_read_reg
                                    && !tx_reg[7]; // [R3] [R10]
                                tx_reg <= {tx_reg[6:0], 1'b0};
                            end
                        end
                        2'h1: scl_low_reg <= 1'b0;
                        2'h2: begin
                            if (bit_idx_reg != 4'h8) begin
                                rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                            end else if (!do_read_reg) begin
                                got_nack_reg <= sda_sync_reg[1]; // [R4]
                            end
                        end
                        2'h3: begin
                            scl_low_reg <= 1'b1;
                            bit_idx_reg <= bit_idx_reg + 4'h1;
                            if (bit_idx_reg == 4'h8) begin
                                sda_low_reg <= 1'b0;
                                state_reg <= do_stop_reg
                                    ? smbus_pkg::HS_STOP
                                    : smbus_pkg::HS_IDLE; // [R7]
                            end
                        end
                    endcase
                end
                smbus_pkg::HS_STOP: begin
                    unique case (phase_reg)
                        2'h0: sda_low_reg <= 1'b1;
                        2'h1: scl_low_reg <= 1'b0;
                        2'h2: sda_low_reg <= 1'b0; // [R2]
                        2'h3: state_reg <= smbus_pkg::HS_IDLE;
                    endcase
                end
                smbus_pkg::HS_IDLE: begin
                end
            endcase
        end
    end

    assign link.scl_host_o = 1'b0;
    assign link.scl_host_oe = scl_low_reg;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = sda_low_reg;
endmodule // smbus_host_master
`default_nettype wire

// ### logic/smbus_link_if.sv
// two-wire link between bus master and memory port
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups
    assign scl = (scl_host_oe && !scl_host_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o))
        ? 1'b0 : 1'b1;

    modport device (
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe
    );
    modport host (
        input scl,
        input sda,
        output scl_host_o,
        output scl_host_oe,
        output sda_host_o,
        output sda_host_oe
    );
endinterface
`default_nettype wire

// ### logic/smbus_pkg.sv
// state types of the two link ends
`default_nettype none
package smbus_pkg;
    typedef enum logic [6:0] {
        DS_IDLE = 7'h01,
        DS_ADDR = 7'h02,
        DS_HDR = 7'h04,
        DS_ADRLO = 7'h08,
        DS_COUNT = 7'h10,
        DS_WDATA = 7'h20,
        DS_TX = 7'h40
    } dev_state_type;

    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_START = 4'h2,
        HS_BIT = 4'h4,
        HS_STOP = 4'h8
    } host_state_type;
endpackage
`default_nettype wire

// ### logic/smbus_slave_device.sv
// two-wire slave port with banked memory and discharge counters
// Behaviour
// R1: slave only; SDA driven open-drain
// R2: start and stop detected while SCL high
// R3: SDA changes only while SCL low
// R4: ninth clock acknowledge held low throughout
// R5: master nacks last read byte
// R6: release SDA after master nack
// R7: any number of data bytes accepted
// R8: repeated start begins new transfer
// R9: address match; direction picks receive or transmit
// R10: write: address, header, low address, count, data
// R11: bank 00 EEPROM, 01 RAM/registers
// R12: 10-bit address plus 2 bank bits
// R13: bus only reads and writes locations
// R14: 512-byte EEPROM; one byte per write
// R15: EEPROM write busy 4 ms; idle acks
// R16: nack EEPROM access while write busy
// R17: RAM/register access unaffected by EEPROM busy
// R18: 32 bytes RAM at bank 1
// R19: negative conversions add to discharge sum
// R20: discharge time counts at 2 Hz
// R21: clear bit zero clears discharge sum
// R22: clear bit one clears discharge time
// R23: header: block bit7, bank 5:4, high 1:0
// R24: block transfers step address within bank
//
// Decided for this implementation: the Wishbone command interface of the host master and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "smbus_defs.svh"
module smbus_slave_device #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int EE_WRITE_CYCLES = `EE_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    smbus_link_if.device link,
    input wire logic conv_valid,
    input wire logic [15:0] sense_voltage,
    output logic eeprom_busy,
    output logic [31:0] discharge_charge_sum,
    output logic [31:0] discharge_time_count
);
    smbus_pkg::dev_state_type state_reg;
    logic [1:0] scl_sync_reg, sda_sync_reg, bank_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg, acc_ctrl_reg, rx_byte, rd_data;
    logic [9:0] ptr_reg;
    logic [23:0] ee_cnt_reg, tick_cnt_reg;
    logic [31:0] sum_reg, time_reg;
    logic scl_prev_reg, sda_prev_reg, sda_low_reg, tx_first_reg;
    logic block_reg, ee_done_reg, sign_reg;
    logic [7:0] ee_mem [512];
    logic [7:0] ram_mem [32];
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    logic byte_in, ee_refuse, wr_ok, mem_we, regs_we;
    logic clr_sum, clr_time, tick, acc_en;
    // pins pass two flops first
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s; // [R2]
    assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s; // [R2]
    assign rx_byte = {shift_reg[6:0], sda_s};
    assign byte_in = scl_rise && bit_cnt_reg == 4'h7;
    assign eeprom_busy = ee_cnt_reg != 24'h000000;
    assign ee_refuse = bank_reg == `BANK_EEPROM && eeprom_busy; // [R16] [R17]
    assign wr_ok = bank_reg != `BANK_EEPROM
        || (!eeprom_busy && !ee_done_reg); // [R14] [R16]
    assign mem_we = byte_in && state_reg == smbus_pkg::DS_WDATA && wr_ok;
    assign regs_we = mem_we && bank_reg == `BANK_REGS; // [R11]
    assign clr_sum = regs_we && ptr_reg == `OFS_ACC_CLR
        && rx_byte[`CLR_SUM_BIT];
    assign clr_time = regs_we && ptr_reg == `OFS_ACC_CLR
        && rx_byte[`CLR_TIME_BIT];
    assign acc_en = acc_ctrl_reg[`ACC_EN_BIT];
    assign tick = tick_cnt_reg == 24'(TICK_CYCLES - 1);
    // read data at the current pointer
    always_comb begin
        rd_data = 8'h00;
        if (bank_reg == `BANK_EEPROM && ptr_reg < `EE_SIZE) begin
            rd_data = ee_mem[ptr_reg[8:0]]; // [R14]
        end else if (bank_reg == `BANK_REGS) begin
            if (ptr_reg < `RAM_SIZE) begin
                rd_data = ram_mem[ptr_reg[4:0]]; // [R18]
            end else if (ptr_reg[9:3] == `OFS_COUNTERS) begin
                rd_data = 8'((ptr_reg[2] ? time_reg : sum_reg)
                    >> {ptr_reg[1:0], 3'h0});
            end else if (ptr_reg == `OFS_ACC_CTRL) begin
                rd_data = acc_ctrl_reg;
            end
        end
    end
    // byte engine and transfer sequencing
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= smbus_pkg::DS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            sda_low_reg <= 1'b0;
            tx_first_reg <= 1'b0;
            ptr_reg <= 10'h000;
            bank_reg <= 2'h0;
            block_reg <= 1'b0;
            ee_done_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= smbus_pkg::DS_ADDR; // [R8]
            bit_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            ee_done_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= smbus_pkg::DS_IDLE;
            sda_low_reg <= 1'b0;
        end else if (state_reg != smbus_pkg::DS_IDLE) begin
            if (scl_rise) begin
                if (bit_cnt_reg != 4'h9) begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                if (bit_cnt_reg < 4'h8) begin
                    shift_reg <= rx_byte;
                end
                if (byte_in) begin
                    unique case (state_reg)
                        smbus_pkg::DS_ADDR: begin
                            if (rx_byte[7:1] != `SLAVE_ADDR) begin // [R9]
                                state_reg <= smbus_pkg::DS_IDLE;
                            end else if (!rx_byte[0]) begin
                                state_reg <= smbus_pkg::DS_HDR; // [R10]
                            end else if (ee_refuse) begin
                                state_reg <= smbus_pkg::DS_IDLE; // [R16]
                            end else begin
                                state_reg <= smbus_pkg::DS_TX; // [R9]
                                tx_first_reg <= 1'b1;
                            end
                        end
                        smbus_pkg::DS_HDR: begin
                            block_reg <= rx_byte[`HDR_BLOCK_BIT]; // [R23]
                            bank_reg <= rx_byte[`HDR_BANK_HI:`HDR_BANK_LO];
                            ptr_reg[9:8] <= rx_byte[`HDR_AH_HI:0]; // [R12]
                            state_reg <= smbus_pkg::DS_ADRLO;
                        end
                        smbus_pkg::DS_ADRLO: begin
                            ptr_reg[7:0] <= rx_byte;
                            if (ee_refuse) begin
                                state_reg <= smbus_pkg::DS_IDLE; // [R16]
                            end else if (block_reg) begin
                                state_reg <= smbus_pkg::DS_COUNT;
                            end else begin
                                state_reg <= smbus_pkg::DS_WDATA;
                            end
                        end
                        smbus_pkg::DS_COUNT: begin
                            state_reg <= smbus_pkg::DS_WDATA; // [R7]
                        end
                        smbus_pkg::DS_WDATA: begin
                            if (!wr_ok) begin
                                state_reg <= smbus_pkg::DS_IDLE; // [R14]
                            end else begin
                                ptr_reg <= ptr_reg + 10'h001; // [R24]
                                if (bank_reg == `BANK_EEPROM) begin
                                    ee_done_reg <= 1'b1;
                                end
                            end
                        end
                        smbus_pkg::DS_IDLE, smbus_pkg::DS_TX: begin
                        end
                    endcase
                end
                if (bit_cnt_reg == 4'h8 && state_reg == smbus_pkg::DS_TX
                    && !tx_first_reg && sda_s) begin
                    state_reg <= smbus_pkg::DS_IDLE; // [R5] [R6]
                end
            end else if (scl_fall) begin
                if (bit_cnt_reg == 4'h8) begin
                    sda_low_reg <= state_reg != smbus_pkg::DS_TX
                        || tx_first_reg; // [R4]
                end else if (bit_cnt_reg == 4'h9) begin
                    bit_cnt_reg <= 4'h0;
                    tx_first_reg <= 1'b0;
                    if (state_reg == smbus_pkg::DS_TX) begin
                        tx_reg <= rd_data;
                        sda_low_reg <= !rd_data[7]; // [R3]
                        ptr_reg <= ptr_reg + 10'h001; // [R24]
                    end else begin
                        sda_low_reg <= 1'b0;
                    end
                end else if (state_reg == smbus_pkg::DS_TX
                    && bit_cnt_reg != 4'h0) begin
                    sda_low_reg <= !tx_reg[6]; // [R3]
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
            end
        end
    end
    // open drain: only ever pulls low
    assign link.sda_dev_o = 1'b0; // [R1]
    assign link.sda_dev_oe = sda_low_reg; // [R1]
    // storage written only by bus data bytes
    always_ff @(posedge clk) begin
        if (mem_we && bank_reg == `BANK_EEPROM && ptr_reg < `EE_SIZE) begin
            ee_mem[ptr_reg[8:0]] <= rx_byte; // [R13] [R14]
        end
        if (regs_we && ptr_reg < `RAM_SIZE) begin
            ram_mem[ptr_reg[4:0]] <= rx_byte; // [R18]
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_ctrl_reg <= `ACC_CTRL_RESET;
        end else if (regs_we && ptr_reg == `OFS_ACC_CTRL) begin
            acc_ctrl_reg <= rx_byte; // [R13]
        end
    end
    // programming cycle timer
    always_ff @(posedge clk) begin
        if (reset) begin
            ee_cnt_reg <= 24'h000000;
        end else if (mem_we && bank_reg == `BANK_EEPROM
            && ptr_reg < `EE_SIZE) begin
            ee_cnt_reg <= 24'(EE_WRITE_CYCLES); // [R15]
        end else if (eeprom_busy) begin
            ee_cnt_reg <= ee_cnt_reg - 24'h000001;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            tick_cnt_reg <= 24'h000000;
        end else if (tick) begin
            tick_cnt_reg <= 24'h000000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 24'h000001;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            sign_reg <= 1'b0;
        end else if (conv_valid) begin
            sign_reg <= sense_voltage[`SIGN_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (reset || clr_sum) begin
            sum_reg <= 32'h00000000; // [R21]
        end else if (conv_valid && acc_en && sense_voltage[`SIGN_BIT]) begin
            sum_reg <= sum_reg + {16'h0000, 16'(-sense_voltage)}; // [R19]
        end
    end
    always_ff @(posedge clk) begin
        if (reset || clr_time) begin
            time_reg <= 32'h00000000; // [R22]
        end else if (tick && acc_en && sign_reg) begin
            time_reg <= time_reg + 32'h00000001; // [R20]
        end
    end
    assign discharge_charge_sum = sum_reg;
    assign discharge_time_count = time_reg;
endmodule // smbus_slave_device
`default_nettype wire

// ### tb/smbus_link_sva.sv
// assertions on the two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
module smbus_link_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_host_oe,
    input wire logic scl_host_oe
);
    logic [7:0] low_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // cycles that scl has been low, saturating
    always_ff @(posedge clk) begin
        if (reset || scl) begin
            low_cnt_reg <= 8'h00;
        end else if (low_cnt_reg != 8'hFF) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
        end
    end
    a_dev_open_drain: assert property (
        sda_dev_oe |-> !sda_dev_o) else $error("device drives sda high");
    a_dev_change_low: assert property (
        $changed(sda_dev_oe) |-> !scl && !$past(scl, 2))
        else $error("device sda moved near scl high");
    a_ack_held_high: assert property (
        $rose(scl) && sda_dev_oe |=> sda_dev_oe [*8])
        else $error("device low bit not held");
    a_silent_after_stop: assert property (
        scl && $rose(sda) |=> !sda_dev_oe [*4])
        else $error("device drives after stop");
    a_reset_lines_free: assert property (
        $past(reset) |-> !sda_dev_oe && !sda_host_oe && !scl_host_oe)
        else $error("line held after reset");
    a_start_bus_free: assert property (
        scl && $rose(sda_host_oe) |-> !sda_dev_oe)
        else $error("start while device holds sda");
    a_scl_high_time: assert property (
        $rose(scl) |=> scl [*8]) else $error("scl high too short");
    a_scl_low_time: assert property (
        $rose(scl) |-> low_cnt_reg >= 8'h14) else $error("scl low too short");
    cover property ($rose(scl) && sda_dev_oe);
    cover property (scl && $fell(sda));
    cover property (scl && $rose(sda));
endmodule // smbus_link_sva
`default_nettype wire

// ### tb/smbus_slave_banked_memory_port_bench.sv
// bench: host master and memory port facing each other
`timescale 1ns/1ps
`default_nettype none
`include "smbus_defs.svh"
module smbus_slave_banked_memory_port_bench;
    localparam logic [11:0] ST = 12'h100;
    localparam logic [11:0] SP = 12'h200;
    localparam logic [11:0] RD = 12'h400;
    localparam logic [11:0] NK = 12'h800;
    localparam logic [11:0] WA = {4'h0, `SLAVE_ADDR, 1'b0};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic conv_valid = 1'b0;
    logic [15:0] sense = 16'h0000;
    logic ack, ee_busy;
    logic [31:0] rdat, sum, tcount, st;
    int fail_count = 0;
    int comparisons = 0;
    smbus_link_if link();
    smbus_slave_device #(.TICK_CYCLES(20), .EE_WRITE_CYCLES(20000))
        i_smbus_slave_device (.clk(clk), .reset(reset), .link(link),
        .conv_valid(conv_valid), .sense_voltage(sense),
        .eeprom_busy(ee_busy), .discharge_charge_sum(sum),
        .discharge_time_count(tcount));
    smbus_host_master i_smbus_host_master (.clk(clk), .reset(reset),
        .link(link), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack));
    smbus_link_sva i_smbus_link_sva (.clk(clk), .reset(reset),
        .scl(link.scl), .sda(link.sda), .sda_dev_o(link.sda_dev_o),
        .sda_dev_oe(link.sda_dev_oe), .sda_host_oe(link.sda_host_oe),
        .scl_host_oe(link.scl_host_oe));
    always #25 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic [31:0] d,
        input logic w);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        dat <= d;
        we <= w;
        do @(posedge clk); while (ack !== 1'b1);
        st = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // one byte on the link, then wait for the host to go idle
    task automatic put(input logic [11:0] c, input logic nak);
        wb(`WB_CMD, {20'h0, c}, 1'b1);
        do wb(`WB_STATUS, 32'h0, 1'b0); while (st[0] === 1'b1);
        if (c[10] === 1'b0) chk({31'h0, st[1]}, {31'h0, nak}, "ack");
    endtask
    task automatic ptr(input logic [7:0] hdr, input logic [7:0] lo,
        input logic nak);
        put(ST | WA, 1'b0);
        put({4'h0, hdr}, 1'b0);
        put({4'h0, lo}, nak);
    endtask
    task automatic conv(input logic [15:0] v);
        @(posedge clk);
        conv_valid <= 1'b1;
        sense <= v;
        @(posedge clk);
        conv_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_ram;
        ptr(8'h90, 8'h1E, 1'b0);
        put(12'h002, 1'b0);
        put(12'h05A, 1'b0);
        put(SP | 12'h0C3, 1'b0);
        ptr(8'h10, 8'h1E, 1'b0);
        put(ST | WA | 12'h001, 1'b0);
        put(RD, 1'b0);
        chk({24'h0, st[15:8]}, 32'h5A, "ram byte");
        put(RD | NK | SP, 1'b0);
        chk({24'h0, st[15:8]}, 32'hC3, "ram next");
        $display("ram test done");
    endtask
    task automatic t_eeprom;
        put(ST | SP | (WA ^ 12'h002), 1'b1);
        ptr(8'h00, 8'h07, 1'b0);
        put(SP | 12'h03C, 1'b0);
        chk({31'h0, ee_busy}, 32'h1, "busy");
        ptr(8'h00, 8'h08, 1'b1);
        put(SP | 12'h011, 1'b1);
        put(ST | SP | WA | 12'h001, 1'b1);
        ptr(8'h10, 8'h00, 1'b0);
        put(SP | 12'h077, 1'b0);
        chk({31'h0, ee_busy}, 32'h1, "busy end");
        while (ee_busy === 1'b1) @(posedge clk);
        ptr(8'h00, 8'h07, 1'b0);
        put(ST | WA | 12'h001, 1'b0);
        put(RD | NK | SP, 1'b0);
        chk({24'h0, st[15:8]}, 32'h3C, "eeprom byte");
        $display("eeprom test done");
    endtask
    task automatic t_count;
        logic [31:0] t0;
        conv(16'hFFF0);
        chk(sum, 32'h0, "sum disabled");
        ptr(8'h10, 8'h63, 1'b0);
        put(SP | 12'h001, 1'b0);
        conv(16'hFFF0);
        conv(16'h0010);
        conv(16'h8000);
        chk(sum, 32'h8010, "sum");
        t0 = tcount;
        repeat (200) @(posedge clk);
        chk(tcount - t0, 32'h0000000A, "time");
        ptr(8'h10, 8'h21, 1'b0);
        put(ST | WA | 12'h001, 1'b0);
        put(RD | NK | SP, 1'b0);
        chk({24'h0, st[15:8]}, 32'h80, "sum byte");
        conv(16'h0010);
        ptr(8'h10, 8'h62, 1'b0);
        put(SP | 12'h003, 1'b0);
        chk(sum, 32'h0, "sum clear");
        chk(tcount, 32'h0, "time clear");
        $display("counter test done");
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (5) @(posedge clk);
        t_ram();
        t_eeprom();
        t_count();
        close_out();
    end
    initial begin
        repeat (95000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule // smbus_slave_banked_memory_port_bench
`default_nettype wire
